/* File: logic/eio_cell_array.sv */
// Byte-wide model of the EEPROM array, registered read
`timescale 1ns/1ps
module eio_cell_array #(
  parameter int DEPTH = 1024,
  parameter int AW = 10
) (
  input wire logic sys_clk,
  input wire logic wrEn,
  input wire logic [AW-1:0] wrAddr,
  input wire logic [7:0] wrData,
  input wire logic [AW-1:0] rdAddr,
  output logic [7:0] rdData
);
  logic [7:0] mem [DEPTH];
  if (DEPTH > (1 << AW)) begin : g_depth_check
    $error("eio_cell_array: depth exceeds address range");
  end
  always_ff @(posedge sys_clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
    rdData <= mem[rdAddr];
  end
endmodule : eio_cell_array

/* File: logic/eio_prog_timer.sv */
// Programming-time counter driven by a divided oscillator enable
`timescale 1ns/1ps
module eio_prog_timer #(
  parameter int unsigned DIV = 3,
  parameter int unsigned CW = 16
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic load,
  input wire logic [CW-1:0] loadValue,
  output logic done
);
  logic [7:0] divQ, divD;
  logic [CW-1:0] cntQ, cntD;
  logic busyQ, busyD;
  logic doneD;
  if (DIV < 1 || DIV > 255) begin : g_div_check
    $error("eio_prog_timer: divider out of range");
  end
  always_comb begin
    divD = divQ;
    cntD = cntQ;
    busyD = busyQ;
    doneD = 1'b0;
    if (load) begin
      cntD = loadValue;
      busyD = 1'b1;
      divD = 8'h00;
    end else if (busyQ) begin
      if (divQ == 8'(DIV - 1)) begin
        divD = 8'h00;
        // One decrement per oscillator tick
        if (cntQ <= CW'(1)) begin
          cntD = '0;
          busyD = 1'b0;
          doneD = 1'b1;
        end else begin
          cntD = cntQ - CW'(1);
        end
      end else begin
        divD = divQ + 8'h01;
      end
    end
  end
  // Reset only takes hold while idle, so a write already started still finishes
  always_ff @(posedge sys_clk) begin
    if (reset_n || busyQ || load) begin
      divQ <= divD;
      cntQ <= cntD;
      busyQ <= busyD;
      done <= doneD;
    end else begin
      divQ <= 8'h00;
      cntQ <= '0;
      busyQ <= 1'b0;
      done <= 1'b0;
    end
  end
endmodule : eio_prog_timer

/* File: logic/eio_regs.sv */
// EEPROM access registers and general-purpose bytes on the CPU I/O bus
`timescale 1ns/1ps
module eio_regs
  import eio_pkg::*;
#(
  parameter int unsigned ATOMIC_CYCLES = OSC_CYCLES_ATOMIC,
  parameter int unsigned SPLIT_CYCLES = OSC_CYCLES_SPLIT
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic ioSpace,
  input wire logic [7:0] busAddr,
  input wire logic busWrite,
  input wire logic busRead,
  input wire logic bitOp,
  input wire logic [2:0] bitSel,
  input wire logic bitValue,
  input wire logic [7:0] busWrData,
  output logic [7:0] busRdData,
  output logic bitTest,
  output logic cpuStall,
  output logic readyIrq
);
  localparam int CW = 16;
  if (ATOMIC_CYCLES <= SPLIT_CYCLES || ATOMIC_CYCLES > 65535 || SPLIT_CYCLES < 1
      || SPLIT_CYCLES > 65535) begin : g_count_check
    $error("eio_regs: programming counts out of range");
  end

  // Bus address translated to data space; -1 marks no register
  function automatic logic [8:0] data_addr(input logic io, input logic [7:0] a);
    logic [8:0] r;
    r = {1'b0, a};
    if (io) begin
      if (a > IO_TOP) begin
        r = 9'h1FF;
      end else begin
        r = 9'({1'b0, a} + {1'b0, IO_TO_DATA});
      end
    end
    return r;
  endfunction : data_addr

  function automatic logic [7:0] set_bit(input logic [7:0] v, input logic [2:0] b,
                                         input logic x);
    logic [7:0] r;
    r = v;
    r[b] = x;
    return r;
  endfunction : set_bit

  logic [8:0] dAddr;
  logic bitOk;
  logic [7:0] ctlView;
  logic [7:0] wrByte;
  logic wrEff;

  logic [1:0] modeQ, modeD;
  logic rieQ, rieD, mweQ, mweD, wsQ, wsD;
  logic [2:0] mweCntQ, mweCntD;
  logic [7:0] dataQ, dataD;
  logic [ADDR_BITS-1:0] addrQ, addrD;
  logic [7:0] tempQ, tempD;
  logic [7:0] gp0Q, gp0D, gp1Q, gp1D, gp2Q, gp2D;
  logic [2:0] stallQ, stallD;
  logic rdPendQ, rdPendD;
  eio_state_t stateQ, stateD;
  logic [7:0] rdD;
  logic bitTestD;

  logic arrWr;
  logic [7:0] arrWrData;
  logic [7:0] arrRd;
  logic timerLoad;
  logic [CW-1:0] timerValue;
  logic timerDone;

  eio_cell_array #(.DEPTH(1024), .AW(ADDR_BITS)) u_array (
    .sys_clk(sys_clk),
    .wrEn(arrWr),
    .wrAddr(addrQ),
    .wrData(arrWrData),
    .rdAddr(addrQ),
    .rdData(arrRd)
  );

  eio_prog_timer #(.DIV(OSC_DIV), .CW(CW)) u_timer (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .load(timerLoad),
    .loadValue(timerValue),
    .done(timerDone)
  );

  assign ctlView = {2'b00, modeQ, rieQ, mweQ, wsQ, 1'b0};

  always_comb begin
    dAddr = data_addr(ioSpace, busAddr);
    // Single-bit access only in the low I/O window
    bitOk = ioSpace && bitOp && (busAddr <= BIT_IO_TOP);
    wrEff = busWrite && (!bitOp || bitOk);
    wrByte = busWrData;
    if (bitOk) begin
      // Read-modify of only the addressed bit; others written back as is
      if (dAddr == 9'(OFS_CONTROL)) begin
        wrByte = set_bit(ctlView, bitSel, bitValue);
      end else if (dAddr == 9'(OFS_GP0)) begin
        wrByte = set_bit(gp0Q, bitSel, bitValue);
      end else begin
        wrByte = 8'h00;
      end
    end
  end

  always_comb begin
    modeD = modeQ;
    rieD = rieQ;
    mweD = mweQ;
    mweCntD = mweCntQ;
    wsD = wsQ;
    dataD = dataQ;
    addrD = addrQ;
    tempD = tempQ;
    gp0D = gp0Q;
    gp1D = gp1Q;
    gp2D = gp2Q;
    stallD = (stallQ != 3'h0) ? stallQ - 3'h1 : 3'h0;
    rdPendD = 1'b0;
    stateD = stateQ;
    rdD = 8'h00;
    bitTestD = 1'b0;
    arrWr = 1'b0;
    arrWrData = dataQ;
    timerLoad = 1'b0;
    timerValue = CW'(ATOMIC_CYCLES);

    // Master enable window
    if (mweQ) begin
      if (mweCntQ == MWE_CYCLES - 3'h1) begin
        mweD = 1'b0;
        mweCntD = 3'h0;
      end else begin
        mweCntD = mweCntQ + 3'h1;
      end
    end

    // Array read lands one cycle after the strobe
    if (rdPendQ) begin
      dataD = arrRd;
    end

    // Programming sequence
    case (stateQ)
      EIO_IDLE: begin
      end
      EIO_ERASE: begin
        if (timerDone) begin
          arrWr = 1'b1;
          arrWrData = 8'hFF;
          if (modeQ == MODE_ATOMIC) begin
            timerLoad = 1'b1;
            timerValue = CW'(ATOMIC_CYCLES - SPLIT_CYCLES);
            stateD = EIO_PROG;
          end else begin
            wsD = 1'b0;
            stateD = EIO_IDLE;
          end
        end
      end
      EIO_PROG: begin
        if (timerDone) begin
          arrWr = 1'b1;
          // Program-only can pull bits low, never raise them
          arrWrData = (modeQ == MODE_WRITE) ? (arrRd & dataQ) : dataQ;
          wsD = 1'b0;
          stateD = EIO_IDLE;
        end
      end
      default: stateD = EIO_IDLE;
    endcase

    if (busRead) begin
      // Extended region hidden from port instructions
      if (dAddr == 9'h1FF || (ioSpace && busAddr >= EXT_LOW)) begin
        rdD = 8'h00;
      end else if (dAddr == 9'(OFS_CONTROL)) begin
        rdD = ctlView;
      end else if (dAddr == 9'(OFS_DATA)) begin
        rdD = dataQ;
      end else if (dAddr == 9'(OFS_ADDR_LOW)) begin
        rdD = addrQ[7:0];
        tempD = {6'h00, addrQ[ADDR_BITS-1:8]};
      end else if (dAddr == 9'(OFS_ADDR_HIGH)) begin
        rdD = tempQ;
      end else if (dAddr == 9'(OFS_TEMP)) begin
        rdD = tempQ;
      end else if (dAddr == 9'(OFS_GP0)) begin
        rdD = gp0Q;
      end else if (dAddr == 9'(OFS_GP1)) begin
        rdD = gp1Q;
      end else if (dAddr == 9'(OFS_GP2)) begin
        rdD = gp2Q;
      end
      if (bitOk) begin
        bitTestD = rdD[bitSel];
      end
    end

    if (wrEff && dAddr != 9'h1FF) begin
      if (dAddr == 9'(OFS_CONTROL)) begin
        rieD = wrByte[RIE_BIT];
        if (!wsQ) begin
          modeD = wrByte[MODE_HI:MODE_LO];
        end
        if (wrByte[MWE_BIT] && !mweQ) begin
          mweD = 1'b1;
          mweCntD = 3'h0;
        end
        if (wrByte[WS_BIT] && !wsQ && mweQ) begin
          mweD = 1'b0;
          stallD = WRITE_STALL;
          if (!wsQ && wrByte[MODE_HI:MODE_LO] == MODE_RESV && modeQ == MODE_RESV) begin
            wsD = 1'b0;
          end else begin
            wsD = 1'b1;
            timerLoad = 1'b1;
            timerValue = (modeQ == MODE_ATOMIC) ? CW'(SPLIT_CYCLES) : CW'(SPLIT_CYCLES);
            stateD = (modeQ == MODE_WRITE) ? EIO_PROG : EIO_ERASE;
          end
        end
        if (modeQ == MODE_RESV && wrByte[WS_BIT] && mweQ) begin
          wsD = 1'b0;
          stateD = EIO_IDLE;
          timerLoad = 1'b0;
        end
        if (wrByte[RS_BIT] && !wsQ) begin
          rdPendD = 1'b1;
          stallD = READ_STALL;
        end
      end else if (dAddr == 9'(OFS_DATA)) begin
        dataD = wrByte;
      end else if (dAddr == 9'(OFS_ADDR_LOW)) begin
        tempD = wrByte;
      end else if (dAddr == 9'(OFS_ADDR_HIGH)) begin
        if (!wsQ) begin
          addrD = {wrByte[ADDR_BITS-9:0], tempQ};
        end
      end else if (dAddr == 9'(OFS_TEMP)) begin
        tempD = wrByte;
      end else if (dAddr == 9'(OFS_GP0)) begin
        gp0D = wrByte;
      end else if (dAddr == 9'(OFS_GP1)) begin
        gp1D = wrByte;
      end else if (dAddr == 9'(OFS_GP2)) begin
        gp2D = wrByte;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      // Mode kept while programming; see reset gating below
      rieQ <= 1'b0;
      mweQ <= 1'b0;
      mweCntQ <= 3'h0;
      dataQ <= RST_DATA;
      tempQ <= 8'h00;
      gp0Q <= RST_GP;
      gp1Q <= RST_GP;
      gp2Q <= RST_GP;
      stallQ <= 3'h0;
      rdPendQ <= 1'b0;
      busRdData <= 8'h00;
      bitTest <= 1'b0;
      cpuStall <= 1'b0;
      readyIrq <= 1'b0;
    end else begin
      rieQ <= rieD;
      mweQ <= mweD;
      mweCntQ <= mweCntD;
      dataQ <= dataD;
      tempQ <= tempD;
      gp0Q <= gp0D;
      gp1Q <= gp1D;
      gp2Q <= gp2D;
      stallQ <= stallD;
      rdPendQ <= rdPendD;
      busRdData <= rdD;
      bitTest <= bitTestD;
      cpuStall <= (stallD != 3'h0);
      readyIrq <= rieD && !wsD;
    end
  end

  // A write in flight finishes across reset, so its state is not reset
  always_ff @(posedge sys_clk) begin
    if (!reset_n && stateQ == EIO_IDLE) begin
      modeQ <= RST_MODE;
      wsQ <= 1'b0;
      stateQ <= EIO_IDLE;
    end else begin
      modeQ <= modeD;
      wsQ <= wsD;
      stateQ <= stateD;
    end
  end

  // Address is undefined after reset by design
  always_ff @(posedge sys_clk) begin
    addrQ <= addrD;
  end
endmodule : eio_regs

/* File: pkg/eio_pkg.sv */
// Constants and types for the EEPROM I/O register block
package eio_pkg;
  localparam int unsigned CLK_HZ = 25000000;
  // I/O window, data-space offset of that window, extended region
  localparam logic [7:0] IO_TOP = 8'h3F;
  localparam logic [7:0] IO_TO_DATA = 8'h20;
  localparam logic [7:0] BIT_IO_TOP = 8'h1F;
  localparam logic [7:0] EXT_LOW = 8'h60;
  localparam logic [7:0] EXT_HIGH = 8'hFF;
  // Data-space offsets
  localparam logic [7:0] OFS_CONTROL = 8'h3F;
  localparam logic [7:0] OFS_DATA = 8'h40;
  localparam logic [7:0] OFS_ADDR_LOW = 8'h41;
  localparam logic [7:0] OFS_ADDR_HIGH = 8'h42;
  localparam logic [7:0] OFS_GP0 = 8'h3E;
  localparam logic [7:0] OFS_GP1 = 8'h4A;
  localparam logic [7:0] OFS_GP2 = 8'h4B;
  localparam logic [7:0] OFS_TEMP = 8'h4C;
  // Control register fields
  localparam int MODE_HI = 5;
  localparam int MODE_LO = 4;
  localparam int RIE_BIT = 3;
  localparam int MWE_BIT = 2;
  localparam int WS_BIT = 1;
  localparam int RS_BIT = 0;
  localparam logic [7:0] RST_DATA = 8'h00;
  localparam logic [7:0] RST_GP = 8'h00;
  localparam logic [1:0] RST_MODE = 2'h0;
  localparam logic [1:0] MODE_ATOMIC = 2'h0;
  localparam logic [1:0] MODE_ERASE = 2'h1;
  localparam logic [1:0] MODE_WRITE = 2'h2;
  localparam logic [1:0] MODE_RESV = 2'h3;
  // Timing
  localparam logic [2:0] MWE_CYCLES = 3'h4;
  localparam logic [2:0] READ_STALL = 3'h4;
  localparam logic [2:0] WRITE_STALL = 3'h2;
  localparam int unsigned OSC_CYCLES_ATOMIC = 26368;
  localparam int unsigned OSC_CYCLES_SPLIT = 13184;
  localparam int unsigned OSC_DIV = 3;
  localparam int ADDR_BITS = 10;
  typedef enum logic [1:0] {EIO_IDLE, EIO_ERASE, EIO_PROG} eio_state_t;
endpackage : eio_pkg

/* File: test/eio_cpu_model.sv */
// CPU-side bus master model issuing one access at a time
`timescale 1ns/1ps
module eio_cpu_model (
  input wire logic sys_clk,
  input wire logic cpuStall,
  input wire logic [7:0] busRdData,
  input wire logic bitTest,
  output logic ioSpace,
  output logic [7:0] busAddr,
  output logic busWrite,
  output logic busRead,
  output logic bitOp,
  output logic [2:0] bitSel,
  output logic bitValue,
  output logic [7:0] busWrData
);
  initial begin
    {ioSpace, busWrite, busRead, bitOp, bitValue} = 5'h0;
    busAddr = 8'h00;
    bitSel = 3'h0;
    busWrData = 8'h00;
  end
  // Single access, never interleaved with another; d[3:0] carries bit value and index
  task automatic acc(input logic io, input logic [7:0] a, input logic w, input logic b,
    input logic [7:0] d, output logic [7:0] rd);
    #1;
    while (cpuStall) @(posedge sys_clk) #1;
    @(posedge sys_clk);
    ioSpace <= io;
    busAddr <= a;
    busWrite <= w;
    busRead <= !w;
    bitOp <= b;
    bitSel <= d[2:0];
    bitValue <= d[3];
    busWrData <= d;
    @(posedge sys_clk);
    busWrite <= 1'b0;
    busRead <= 1'b0;
    bitOp <= 1'b0;
    // Released bus shows inverted values so stale data cannot pass
    busAddr <= ~a;
    busWrData <= ~d;
    #1;
    rd = b ? {7'h0, bitTest} : busRdData;
  endtask : acc
endmodule : eio_cpu_model

/* File: test/eio_regs_checker.sv */
// Port-level assertions for the EEPROM register block
`timescale 1ns/1ps
module eio_regs_checker
  import eio_pkg::*;
#(
  parameter int unsigned ATOMIC_CYCLES = OSC_CYCLES_ATOMIC,
  parameter int unsigned SPLIT_CYCLES = OSC_CYCLES_SPLIT
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic ioSpace,
  input wire logic [7:0] busAddr,
  input wire logic busWrite,
  input wire logic busRead,
  input wire logic bitOp,
  input wire logic [2:0] bitSel,
  input wire logic bitValue,
  input wire logic [7:0] busWrData,
  input wire logic [7:0] busRdData,
  input wire logic bitTest,
  input wire logic cpuStall,
  input wire logic readyIrq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  logic [2:0] mweAge_q, mweAge_d, run_q, run_d;
  logic ctlWr, ctlHit;
  // Any write to control, whole byte or single bit
  assign ctlHit = busWrite &&
    (ioSpace ? busAddr == OFS_CONTROL - IO_TO_DATA : busAddr == OFS_CONTROL);
  assign ctlWr = ctlHit && !bitOp;
  // Age of the last master-enable write, saturating so it never wraps into the window
  always_comb begin
    mweAge_d = (mweAge_q == 3'h7) ? mweAge_q : mweAge_q + 3'h1;
    if (ctlWr && busWrData[MWE_BIT]) begin
      mweAge_d = 3'h0;
    end
    run_d = cpuStall ? run_q + 3'h1 : 3'h0;
  end
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      mweAge_q <= 3'h7;
      run_q <= 3'h0;
    end else begin
      mweAge_q <= mweAge_d;
      run_q <= run_d;
    end
  end
  write_stall_a:
    assert property (ctlWr && busWrData[WS_BIT] && mweAge_q <= 3'h2 && readyIrq
      && busWrData[MODE_HI:MODE_LO] != MODE_RESV
      |=> !readyIrq && cpuStall ##1 cpuStall ##1 !cpuStall)
    else $error("write strobe stall or ready drop wrong");
  resv_strobe_a:
    assert property (ctlWr && busWrData[WS_BIT] && busWrData[RIE_BIT] && mweAge_q <= 3'h2
      && readyIrq && busWrData[MODE_HI:MODE_LO] == MODE_RESV |=> readyIrq [*3])
    else $error("reserved mode strobe started a write");
  no_strobe_a:
    assert property (ctlWr && busWrData[WS_BIT] && busWrData[RIE_BIT] && mweAge_q > 3'h4
      && readyIrq |=> readyIrq && !cpuStall)
    else $error("strobe acted without master enable");
  read_stall_a:
    assert property (ctlWr && busWrData[RS_BIT] && !busWrData[WS_BIT] && readyIrq
      |=> cpuStall[*4] ##1 !cpuStall)
    else $error("read strobe stall wrong");
  stall_max_a:
    assert property (run_q <= 3'h4)
    else $error("stall too long");
  irq_fall_a:
    assert property ($fell(readyIrq) |-> $past(ctlHit))
    else $error("ready request dropped without control write");
  idle_data_a:
    assert property (!busRead |=> busRdData == 8'h00)
    else $error("read data outside read answer");
  unmapped_io_a:
    assert property (busRead && ioSpace && busAddr > IO_TOP |=> busRdData == 8'h00 && !bitTest)
    else $error("port read beyond window returned data");
  bit_test_a:
    assert property (!(busRead && bitOp) |=> !bitTest)
    else $error("bit test without bit read");
  cover property (ctlWr && busWrData[WS_BIT] && mweAge_q <= 3'h2);
  cover property (ctlWr && busWrData[RS_BIT] && readyIrq);
  cover property (busRead && bitOp ##1 bitTest);
endmodule : eio_regs_checker

bind eio_regs eio_regs_checker #(
  .ATOMIC_CYCLES(ATOMIC_CYCLES),
  .SPLIT_CYCLES(SPLIT_CYCLES)
) u_chk (.sys_clk(sys_clk), .reset_n(reset_n), .ioSpace(ioSpace), .busAddr(busAddr),
  .busWrite(busWrite), .busRead(busRead), .bitOp(bitOp), .bitSel(bitSel),
  .bitValue(bitValue), .busWrData(busWrData), .busRdData(busRdData), .bitTest(bitTest),
  .cpuStall(cpuStall), .readyIrq(readyIrq));

/* File: test/test_eio_regs.sv */
// Self-checking bench for the EEPROM register block
`timescale 1ns/1ps
module test_eio_regs
  import eio_pkg::*;
();
  // Short programming counts keep the run brief
  localparam int AT = 20;
  localparam int SP = 10;
  localparam logic [7:0] GPD [3] = '{OFS_GP0, OFS_GP1, OFS_GP2};
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic ioSpace, busWrite, busRead, bitOp, bitValue, bitTest, cpuStall, readyIrq;
  logic [7:0] busAddr, busWrData, busRdData, got;
  logic [2:0] bitSel;
  int errors = 0;
  int samples_checked = 0;
  always #20 sys_clk = ~sys_clk;
  eio_regs #(.ATOMIC_CYCLES(AT), .SPLIT_CYCLES(SP)) u_dut (.sys_clk(sys_clk),
    .reset_n(reset_n), .ioSpace(ioSpace), .busAddr(busAddr), .busWrite(busWrite),
    .busRead(busRead), .bitOp(bitOp), .bitSel(bitSel), .bitValue(bitValue),
    .busWrData(busWrData), .busRdData(busRdData), .bitTest(bitTest),
    .cpuStall(cpuStall), .readyIrq(readyIrq));
  eio_cpu_model u_cpu (.sys_clk(sys_clk), .cpuStall(cpuStall), .busRdData(busRdData),
    .bitTest(bitTest), .ioSpace(ioSpace), .busAddr(busAddr), .busWrite(busWrite),
    .busRead(busRead), .bitOp(bitOp), .bitSel(bitSel), .bitValue(bitValue),
    .busWrData(busWrData));
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic io, input logic [7:0] a, input logic [7:0] d);
    u_cpu.acc(io, a, 1'b1, 1'b0, d, got);
  endtask : wr
  task automatic rd(input logic io, input logic [7:0] a, input logic [7:0] e,
    input logic [7:0] m = 8'hFF);
    u_cpu.acc(io, a, 1'b0, 1'b0, 8'h00, got);
    chk($sformatf("read %h", a), e & m, got & m);
  endtask : rd
  task automatic bw(input logic [7:0] a, input logic [2:0] s, input logic v);
    u_cpu.acc(1'b1, a, 1'b1, 1'b1, {4'h0, v, s}, got);
  endtask : bw
  task automatic bt(input logic [7:0] a, input logic [2:0] s, input logic e);
    u_cpu.acc(1'b1, a, 1'b0, 1'b1, {5'h0, s}, got);
    chk("bit test", {7'h0, e}, got);
  endtask : bt
  // Arm and strobe, then time the busy span by the ready request
  task automatic prog(input logic [1:0] m, input int n);
    int k;
    k = 0;
    wr(1'b1, 8'h1F, {2'b00, m, 4'hC});
    wr(1'b1, 8'h1F, {2'b00, m, 4'hA});
    if (m != MODE_RESV) begin
      wr(1'b1, 8'h1F, {2'b00, ~m, 4'hA});
      wr(1'b1, 8'h22, 8'h00);
    end
    while (!readyIrq && k < 400) begin
      @(posedge sys_clk) #1;
      k++;
    end
    chk("busy span", 8'h01, {7'h0, k < 400 && (m == MODE_RESV ||
      (k + 12 >= 3 * n && k <= 3 * n + 6))});
    rd(1'b1, 8'h1F, {2'b00, m, 4'h8}, 8'h3E);
  endtask : prog
  task automatic rback(input logic [7:0] e);
    wr(1'b1, 8'h20, 8'h00);
    wr(1'b1, 8'h1F, 8'h09);
    rd(1'b1, 8'h20, e);
  endtask : rback
  task automatic close_out();
    $display("checked %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : close_out
  initial begin
    repeat (20000) @(posedge sys_clk);
    errors++;
    close_out();
  end
  initial begin
    repeat (20) @(posedge sys_clk);
    reset_n <= 1'b1;
    rd(1'b0, OFS_DATA, RST_DATA);
    rd(1'b0, OFS_CONTROL, 8'h00, 8'h0D);
    for (int i = 0; i < 3; i++) begin
      rd(1'b0, GPD[i], RST_GP);
      wr(1'b1, GPD[i] - IO_TO_DATA, 8'hC3 ^ 8'(i));
      rd(1'b0, GPD[i], 8'hC3 ^ 8'(i));
    end
    wr(1'b1, 8'h20, 8'hA5);
    rd(1'b0, OFS_DATA, 8'hA5);
    rd(1'b1, 8'h40, 8'h00);
    wr(1'b1, 8'h1E, 8'h00);
    bw(8'h1E, 3'd3, 1'b1);
    bw(8'h1E, 3'd7, 1'b1);
    bw(8'h1E, 3'd3, 1'b0);
    rd(1'b1, 8'h1E, 8'h80);
    bt(8'h1E, 3'd7, 1'b1);
    bt(8'h1E, 3'd0, 1'b0);
    bw(8'h2A, 3'd0, 1'b1);
    rd(1'b1, 8'h2A, 8'hC2);
    wr(1'b1, 8'h21, 8'h55);
    rd(1'b0, OFS_TEMP, 8'h55);
    wr(1'b1, 8'h22, 8'h01);
    rd(1'b1, 8'h21, 8'h55);
    rd(1'b0, OFS_TEMP, 8'h01);
    rd(1'b1, 8'h22, 8'h01);
    wr(1'b0, OFS_TEMP, 8'h77);
    wr(1'b0, OFS_ADDR_HIGH, 8'hFF);
    rd(1'b0, OFS_ADDR_LOW, 8'h77);
    rd(1'b1, 8'h22, 8'h03);
    wr(1'b1, 8'h21, 8'h55);
    wr(1'b1, 8'h22, 8'h01);
    wr(1'b1, 8'h20, 8'h5A);
    prog(MODE_ATOMIC, AT);
    rd(1'b1, 8'h21, 8'h55);
    rd(1'b1, 8'h22, 8'h01);
    rback(8'h5A);
    wr(1'b1, 8'h20, 8'h3C);
    prog(MODE_ERASE, SP);
    prog(MODE_WRITE, SP);
    rback(8'h3C);
    prog(MODE_RESV, 0);
    rback(8'h3C);
    wr(1'b1, 8'h1F, 8'h0C);
    repeat (6) @(posedge sys_clk);
    rd(1'b1, 8'h1F, 8'h08, 8'h0E);
    wr(1'b1, 8'h20, 8'h99);
    wr(1'b1, 8'h1F, 8'h0A);
    chk("readyIrq", 8'h01, {7'h0, readyIrq});
    bt(8'h1F, 3'd3, 1'b1);
    rback(8'h3C);
    wr(1'b1, 8'h1F, 8'h2C);
    wr(1'b1, 8'h1F, 8'h2A);
    @(posedge sys_clk) reset_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    reset_n <= 1'b1;
    rd(1'b1, 8'h1F, 8'h20, 8'h3D);
    repeat (80) @(posedge sys_clk);
    reset_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    reset_n <= 1'b1;
    rd(1'b1, 8'h1F, 8'h00, 8'h3F);
    close_out();
  end
endmodule : test_eio_regs
